// *** rtl/tbwc_top.v ***
// Timebase counter with watchdog and input capture, Avalon-MM slave
// Summary of operation
// - Hidden 8-bit counter clears on reset and steps at oscillator divided by 32.
// - Overflow event when counter wraps from F9h to 00h, 250 counts.
// - Timebase select picks 8000 or 16000 oscillator periods per event.
// - Timebase event sets timebase flag; interrupt when its enable is set.
// - Timebase flag clears only on control/status read; writes leave it.
// - Enabled, unrefreshed watchdog resets the device after 2 ms at 8 MHz.
// - Software sets delay bit each period; hardware clears it at period end.
// - Period counted from reset even when disabled; late enable resets at once.
// - Writing force bit while watchdog enabled forces a watchdog reset.
// - Force/status set on watchdog reset; cleared by low-voltage reset or software.
// - Stale force/status bit resets immediately when watchdog next enabled.
// - Hardware watchdog option keeps watchdog active and ignores enable bit.
// - Option selects whether halt resets the device when watchdog enabled.
// - Without that option halt stops counter and suppresses watchdog resets.
// - Wake by interrupt resumes after 256 cycles; wake by reset disables watchdog.
// - Capture pin edge copies counter to capture register and sets capture flag.
// - Set capture flag blocks captures; cleared only by capture register read.
// - Capture flag clears on reset; capture register reads 00h until the first capture.
// - Counter runs in slow, wait, active-halt; stops in halt.
// - Timebase event wakes wait and active-halt; capture wakes halt.
// - Separate timebase and capture interrupt lines, each gated by its enable.
`include "tbwc_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module tbwc_top #(
  parameter WD_TIMEOUT_NS = `TBWC_WD_TIMEOUT_NS,
  parameter CLK_PERIOD_NS = `TBWC_CLK_PERIOD_NS,
  parameter OSC_HZ = `TBWC_OSC_HZ
) (
  input wire clk,
  input wire rst_n,
  input wire lvd_rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire capture_input_pin,
  input wire hw_watchdog_opt,
  input wire halt_reset_opt,
  input wire halt_req,
  input wire wait_mode,
  input wire active_halt_mode,
  input wire ext_wakeup,
  output reg timebase_irq,
  output reg capture_irq,
  output reg halt_wakeup,
  output reg active_wakeup,
  output reg halted,
  output reg watchdog_reset
);
  // Watchdog period in oscillator periods, each watchdog tick being 32 of them
  localparam integer WD_OSC = (WD_TIMEOUT_NS / 1000) * (OSC_HZ / 1000000);
  localparam integer WD_TICKS = WD_OSC / `TBWC_PRESCALE;
  localparam integer WAKE_CYC = `TBWC_WAKE_DELAY;

  reg [7:0] aux_timer;
  reg tb_half;
  reg [9:0] wd_cnt;
  reg [8:0] wake_cnt;
  reg capture_irq_enable;
  reg capture_flag;
  reg timebase_select;
  reg timebase_irq_enable;
  reg timebase_flag;
  reg watchdog_force_status;
  reg watchdog_enable;
  reg watchdog_delay;
  reg [7:0] capture_bits;
  reg cap_pin_q;
  reg wd_pend;
  reg [1:0] bus_st;
  reg fs_read_seen;

  wire tick;
  wire run;
  wire ovf;
  wire tb_event;
  wire wd_period_end;
  wire wd_active;
  wire csr_sel;
  wire cap_sel;
  wire rd_csr;
  wire rd_cap;
  wire wr_csr;
  wire cap_edge;
  wire wd_fire;
  wire halt_rst;
  reg [7:0] csr_view;

  // Two-state handshake: one wait cycle per access
  localparam [1:0] BUS_IDLE = 2'h0;
  localparam [1:0] BUS_ACK = 2'h1;

  // Registers sit on word addresses, index times four
  function sel_hit;
    input [7:0] a;
    input [7:0] idx;
    begin
      sel_hit = (a == {idx[5:0], 2'b00});
    end
  endfunction

  // Counter stops in halt and during the wakeup delay
  assign run = ~halted && (wake_cnt == 9'h000);

  tbwc_prescaler #(.DIV(`TBWC_PRESCALE)) u_pre (
    .clk(clk),
    .clear(~rst_n),
    .run(run),
    .tick(tick)
  );

  assign ovf = tick && (aux_timer == `TBWC_CNT_TOP);
  assign tb_event = ovf && (~timebase_select || tb_half);
  assign wd_period_end = tick && (wd_cnt == WD_TICKS[9:0] - 10'h001);
  assign wd_active = hw_watchdog_opt || watchdog_enable;
  assign csr_sel = sel_hit(avs_address, `TBWC_IDX_CSR);
  assign cap_sel = sel_hit(avs_address, `TBWC_IDX_CAP);
  // Only lane 0 carries the 8-bit registers, so it alone qualifies an access
  // Read strobes only count once, on the acknowledge cycle
  assign rd_csr = avs_read && csr_sel && (bus_st == BUS_ACK) && avs_byteenable[0];
  assign rd_cap = avs_read && cap_sel && (bus_st == BUS_ACK) && avs_byteenable[0];
  assign wr_csr = avs_write && csr_sel && (bus_st == BUS_ACK) && avs_byteenable[0];
  // Any level change is an edge; a set flag holds off further captures
  assign cap_edge = (capture_input_pin != cap_pin_q) && ~capture_flag;
  // Halt only resets when the option strap asks for it
  assign halt_rst = halt_req && wd_active && halt_reset_opt;
  // Timeout, forced reset or stale status each fire while the watchdog is active
  wire wd_timeout;
  wire wd_forced;
  wire wd_stale;
  assign wd_timeout = wd_period_end && ~watchdog_delay;
  assign wd_forced = wr_csr && avs_writedata[`TBWC_BIT_WD_FS];
  assign wd_stale = wd_pend || watchdog_force_status;
  assign wd_fire = wd_active && ~halted && (wd_timeout || wd_forced || wd_stale);

  // Read view of the control/status bits
  always @* begin
    csr_view = 8'h00;
    csr_view[`TBWC_BIT_CAP_IE] = capture_irq_enable;
    csr_view[`TBWC_BIT_CAP_F] = capture_flag;
    csr_view[`TBWC_BIT_TB_SEL] = timebase_select;
    csr_view[`TBWC_BIT_TB_IE] = timebase_irq_enable;
    csr_view[`TBWC_BIT_TB_F] = timebase_flag;
    csr_view[`TBWC_BIT_WD_FS] = watchdog_force_status;
    csr_view[`TBWC_BIT_WD_EN] = watchdog_enable;
    csr_view[`TBWC_BIT_WD_DLY] = watchdog_delay;
  end

  // Bus: one wait cycle then acknowledge
  // Read data is latched on the request edge, before any read-clear lands
  always @(posedge clk) begin
    if (!rst_n) begin
      bus_st <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      case (bus_st)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            if (csr_sel) begin
              avs_readdata <= {24'h000000, csr_view};
            end else if (cap_sel) begin
              avs_readdata <= {24'h000000, capture_bits};
            end else begin
              avs_readdata <= 32'h00000000;
            end
          end
        end
        BUS_ACK: begin
          bus_st <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_st <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Counter and timebase half-period toggle
  always @(posedge clk) begin
    if (!rst_n) begin
      aux_timer <= 8'h00;
      tb_half <= 1'b0;
    end else if (tick) begin
      if (ovf) begin
        aux_timer <= 8'h00;
        tb_half <= ~tb_half;
      end else begin
        aux_timer <= aux_timer + 8'h01;
      end
    end
  end

  // Period runs from reset regardless of enable
  always @(posedge clk) begin
    if (!rst_n) begin
      wd_cnt <= 10'h000;
    end else if (wd_period_end) begin
      wd_cnt <= 10'h000;
    end else if (tick) begin
      wd_cnt <= wd_cnt + 10'h001;
    end
  end

  // Software-owned control bits
  always @(posedge clk) begin
    if (!rst_n) begin
      capture_irq_enable <= 1'b0;
      timebase_select <= 1'b0;
      timebase_irq_enable <= 1'b0;
      watchdog_enable <= 1'b0;
    end else if (wr_csr) begin
      capture_irq_enable <= avs_writedata[`TBWC_BIT_CAP_IE];
      timebase_select <= avs_writedata[`TBWC_BIT_TB_SEL];
      timebase_irq_enable <= avs_writedata[`TBWC_BIT_TB_IE];
      watchdog_enable <= avs_writedata[`TBWC_BIT_WD_EN];
    end
  end

  // Timebase flag; event set wins over a read clear
  always @(posedge clk) begin
    if (!rst_n) begin
      timebase_flag <= 1'b0;
    end else if (tb_event) begin
      timebase_flag <= 1'b1;
    end else if (rd_csr) begin
      timebase_flag <= 1'b0;
    end
  end

  // Capture; pin history loads from the pin so reset makes no false edge
  always @(posedge clk) begin
    if (!rst_n) begin
      capture_flag <= 1'b0;
      capture_bits <= 8'h00;
      cap_pin_q <= capture_input_pin;
    end else begin
      cap_pin_q <= capture_input_pin;
      if (cap_edge) begin
        capture_flag <= 1'b1;
        capture_bits <= aux_timer;
      end else if (rd_cap) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // Delay bit set by software, hardware clears at period end
  always @(posedge clk) begin
    if (!rst_n) begin
      watchdog_delay <= 1'b0;
      wd_pend <= 1'b0;
    end else begin
      if (wr_csr && avs_writedata[`TBWC_BIT_WD_DLY]) begin
        watchdog_delay <= 1'b1;
      end else if (wd_period_end) begin
        watchdog_delay <= 1'b0;
      end
      // A lapsed period while disabled is remembered for the next enable
      if (wd_period_end && ~watchdog_delay && ~wd_active) begin
        wd_pend <= 1'b1;
      end
    end
  end

  // Software may clear the force/status bit only once it has read it
  always @(posedge clk) begin
    if (!rst_n) begin
      fs_read_seen <= 1'b0;
    end else if (rd_csr) begin
      fs_read_seen <= 1'b1;
    end else if (wr_csr) begin
      fs_read_seen <= 1'b0;
    end
  end

  // Force/status survives device reset; only the low-voltage reset or a software write after a read clears it
  always @(posedge clk) begin
    if (!lvd_rst_n) begin
      watchdog_force_status <= 1'b0;
    end else if (wd_fire || halt_rst) begin
      watchdog_force_status <= 1'b1;
    end else if (wr_csr && ~avs_writedata[`TBWC_BIT_WD_FS] && fs_read_seen && rst_n) begin
      watchdog_force_status <= 1'b0;
    end
  end

  // Halt and wakeup; clocks stay on here, the counter is frozen instead
  // Frozen counter also freezes the watchdog period, so no reset while halted
  always @(posedge clk) begin
    if (!rst_n) begin
      halted <= 1'b0;
      wake_cnt <= 9'h000;
    end else if (halted) begin
      if (ext_wakeup || (cap_edge && capture_irq_enable)) begin
        halted <= 1'b0;
        wake_cnt <= WAKE_CYC[8:0];
      end
    end else if (halt_req && ~halt_rst) begin
      halted <= 1'b1;
    end else if (wake_cnt != 9'h000) begin
      wake_cnt <= wake_cnt - 9'h001;
    end
  end

  // Interrupt lines follow flag and enable
  always @(posedge clk) begin
    if (!rst_n) begin
      timebase_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      timebase_irq <= timebase_flag && timebase_irq_enable;
      capture_irq <= capture_flag && capture_irq_enable;
    end
  end

  // Wakeup pulses and the watchdog reset pulse
  always @(posedge clk) begin
    if (!rst_n) begin
      halt_wakeup <= 1'b0;
      active_wakeup <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      halt_wakeup <= halted && cap_edge && capture_irq_enable;
      active_wakeup <= tb_event && timebase_irq_enable &&
                       (wait_mode || active_halt_mode);
      // Low every other cycle so the chip reset logic sees distinct pulses
      watchdog_reset <= (wd_fire || halt_rst) && ~watchdog_reset;
    end
  end
endmodule
`default_nettype wire

// *** rtl/tbwc_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the timebase watchdog
`ifndef TBWC_REGS_VH
`define TBWC_REGS_VH
`define TBWC_IDX_CSR 8'h0B
`define TBWC_IDX_CAP 8'h0C
`define TBWC_ADDR_W 8
`define TBWC_BIT_CAP_IE 7
`define TBWC_BIT_CAP_F 6
`define TBWC_BIT_TB_SEL 5
`define TBWC_BIT_TB_IE 4
`define TBWC_BIT_TB_F 3
`define TBWC_BIT_WD_FS 2
`define TBWC_BIT_WD_EN 1
`define TBWC_BIT_WD_DLY 0
`define TBWC_CSR_RESET 8'h00
`define TBWC_PRESCALE 32
`define TBWC_CNT_TOP 8'hF9
`define TBWC_WD_TIMEOUT_NS 2000000
`define TBWC_OSC_HZ 8000000
`define TBWC_CLK_PERIOD_NS 40
`define TBWC_WAKE_DELAY 256
`endif

// *** rtl/tbwc_prescaler.v ***
// Divide-by-32 prescaler that yields the counter tick
`timescale 1ns/1ns
`default_nettype none
module tbwc_prescaler #(
  parameter DIV = 32
) (
  input wire clk,
  input wire clear,
  input wire run,
  output reg tick
);
  reg [4:0] div_cnt;
  always @(posedge clk) begin
    if (clear) begin
      div_cnt <= 5'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run) begin
        if ({27'h0000000, div_cnt} == DIV - 1) begin
          div_cnt <= 5'h00;
          tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tbwc_props.sv ***
// Port-level assertions for the timebase watchdog capture block
`timescale 1ns/1ns
`default_nettype none
module tbwc_props (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire halt_reset_opt,
  input wire timebase_irq,
  input wire capture_irq,
  input wire halt_wakeup,
  input wire active_wakeup,
  input wire halted,
  input wire watchdog_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge too long");
  property p_unmap; avs_read && avs_waitrequest && avs_address != 8'h2C
    && avs_address != 8'h30 |=> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wd; watchdog_reset |=> !watchdog_reset; endproperty
  a_wd: assert property (p_wd) else $error("watchdog reset too wide");
  // One cycle of slack: the halt and the expiry may land on the same edge
  property p_quiet; halted && $past(halted) && !halt_reset_opt |-> !watchdog_reset; endproperty
  a_quiet: assert property (p_quiet) else $error("watchdog fired while halted");
  property p_hwk; halt_wakeup |=> !halt_wakeup; endproperty
  a_hwk: assert property (p_hwk) else $error("halt wakeup too wide");
  property p_awk; active_wakeup |=> !active_wakeup; endproperty
  a_awk: assert property (p_awk) else $error("active wakeup too wide");
  property p_tbf; $fell(timebase_irq) |-> !$past(avs_waitrequest)
    || !$past(avs_waitrequest, 2); endproperty
  a_tbf: assert property (p_tbf) else $error("timebase irq dropped alone");
  property p_cpf; $fell(capture_irq) |-> !$past(avs_waitrequest)
    || !$past(avs_waitrequest, 2); endproperty
  a_cpf: assert property (p_cpf) else $error("capture irq dropped alone");
endmodule
`default_nettype wire

// *** tb/tbwc_pin_model.sv ***
// Capture pin source standing in for the external signal
`timescale 1ns/1ns
`default_nettype none
module tbwc_pin_model (
  input wire logic clk,
  input wire logic flip,
  output var logic pin
);
  initial pin = 1'b0;
  // One edge per command, alternating rising and falling
  always @(posedge clk) if (flip) pin <= ~pin;
endmodule
`default_nettype wire

// *** tb/tbwc_top_test.sv ***
// Self-checking bench for the timebase watchdog capture block
`timescale 1ns/1ns
`default_nettype none
module tbwc_top_test;
  localparam logic [7:0] CSR = 8'h2C;
  localparam logic [7:0] CAP = 8'h30;
  logic clk = 0, rst_n = 0, low_voltage_reset = 0, rd = 0, wr = 0, flip = 0, hopt = 0, hreq = 0;
  logic ahm = 0, wk = 0, hwo = 0, wq, pin, tbi, cpi, hlt, wdr, awk, hwk;
  logic [7:0] adr = 8'h00, v, v1;
  logic [31:0] wd = 32'h0, rdat;
  int n_errors = 0, n_compared = 0, cyc = 0, wd_n = 0, awk_n = 0, hwk_n = 0, t, n0;
  always #20 clk = ~clk;
  tbwc_pin_model pm (.clk(clk), .flip(flip), .pin(pin));
  // Short watchdog period: 5 ticks, 160 clocks
  tbwc_top #(.WD_TIMEOUT_NS(20000)) uut (.clk(clk), .rst_n(rst_n), .lvd_rst_n(low_voltage_reset),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq),
    .capture_input_pin(pin), .hw_watchdog_opt(hwo), .halt_reset_opt(hopt),
    .halt_req(hreq), .wait_mode(1'b0), .active_halt_mode(ahm), .ext_wakeup(wk),
    .timebase_irq(tbi), .capture_irq(cpi), .halt_wakeup(hwk), .active_wakeup(awk),
    .halted(hlt), .watchdog_reset(wdr));
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    n_compared++;
    if (g != e) begin
      n_errors++;
      $display("mismatch at %0t: count %0d want %0d", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    v = rdat[7:0];
    wr <= 0;
    rd <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk(v, e);
  endtask
  task automatic rst(input logic l);
    @(posedge clk);
    rst_n <= 0;
    low_voltage_reset <= !l;
    step(4);
    rst_n <= 1;
    low_voltage_reset <= 1;
  endtask
  task automatic cap;
    @(posedge clk);
    flip <= 1;
    @(posedge clk);
    flip <= 0;
    step(6);
  endtask
  task automatic waittb;
    step(4);
    while (tbi !== 1'b1) @(posedge clk);
  endtask
  task automatic fired(input int e);
    step(8);
    chkn(int'(wd_n > n0), e);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdr === 1'b1) wd_n <= wd_n + 1;
    if (awk === 1'b1) awk_n <= awk_n + 1;
    if (hwk === 1'b1) hwk_n <= hwk_n + 1;
    if (cyc == 70000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    step(16);
    rst_n <= 1;
    low_voltage_reset <= 1;
    rdc(CSR, 8'h00);
    rdc(CAP, 8'h00);
    bus(1, CAP, 8'h55);
    bus(1, 8'h3C, 8'hFF);
    rdc(8'h3C, 8'h00);
    rdc(CAP, 8'h00);
    ahm <= 1;
    bus(1, CSR, 8'h18);
    rdc(CSR, 8'h10);
    waittb;
    t = cyc;
    rdc(CSR, 8'h18);
    waittb;
    chkn(cyc - t, 8000);
    bus(1, CSR, 8'h38);
    rdc(CSR, 8'h38);
    waittb;
    t = cyc;
    bus(0, CSR, 8'h00);
    waittb;
    chkn(cyc - t, 16000);
    bus(1, CSR, 8'h20);
    step(3);
    chk({7'h0, tbi}, 8'h00);
    rdc(CSR, 8'h28);
    ahm <= 0;
    chkn(int'(awk_n > 0), 1);
    bus(1, CSR, 8'h80);
    t = cyc;
    cap;
    chk({7'h0, cpi}, 8'h01);
    rdc(CSR, 8'hC0);
    bus(0, CAP, 8'h00);
    v1 = v;
    while (cyc != t + 320) @(posedge clk);
    cap;
    rdc(CAP, 8'((v1 + 10) % 250));
    while (cyc != t + 640) @(posedge clk);
    cap;
    step(60);
    cap;
    rdc(CAP, 8'((v1 + 20) % 250));
    n0 = wd_n;
    bus(1, CSR, 8'h02);
    fired(1);
    rst(0);
    rdc(CSR, 8'h04);
    bus(1, CSR, 8'h03);
    rdc(CSR, 8'h03);
    n0 = wd_n;
    repeat (6) begin
      step(100);
      bus(1, CSR, 8'h03);
    end
    fired(0);
    step(330);
    fired(1);
    rst(1);
    rdc(CSR, 8'h00);
    bus(1, CSR, 8'h03);
    n0 = wd_n;
    bus(1, CSR, 8'h07);
    fired(1);
    rst(1);
    bus(1, CSR, 8'h03);
    @(posedge clk) hreq <= 1;
    @(posedge clk) hreq <= 0;
    step(4);
    chk({7'h0, hlt}, 8'h01);
    n0 = wd_n;
    step(400);
    fired(0);
    @(posedge clk) wk <= 1;
    @(posedge clk) wk <= 0;
    step(4);
    chk({7'h0, hlt}, 8'h00);
    bus(1, CSR, 8'h83);
    @(posedge clk) hreq <= 1;
    @(posedge clk) hreq <= 0;
    step(4);
    cap;
    chk({7'h0, hlt}, 8'h00);
    chkn(int'(hwk_n > 0), 1);
    rst(1);
    hopt <= 1;
    bus(1, CSR, 8'h03);
    n0 = wd_n;
    @(posedge clk) hreq <= 1;
    @(posedge clk) hreq <= 0;
    fired(1);
    rst(1);
    hopt <= 0;
    hwo <= 1;
    n0 = wd_n;
    step(200);
    fired(1);
    complete_run;
  end
endmodule
bind tbwc_top tbwc_props chk_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .halt_reset_opt(halt_reset_opt),
  .timebase_irq(timebase_irq), .capture_irq(capture_irq), .halt_wakeup(halt_wakeup),
  .active_wakeup(active_wakeup), .halted(halted), .watchdog_reset(watchdog_reset));
`default_nettype wire
